// [core/etp_pkg.sv]
// Package: register map, fields, timing and types of the energy-to-pulse converter
package etp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MODE_ONE   = 8'h0B;
  localparam logic [7:0] IDX_MODE_TWO   = 8'h0C;
  localparam logic [7:0] IDX_IRQ_EN_LOW = 8'hD9;
  localparam logic [7:0] IDX_IRQ_EN_MID = 8'hDA;
  localparam logic [7:0] IDX_IRQ_EN_HI  = 8'hDB;
  localparam logic [7:0] IDX_IRQ_ST_MID = 8'hDD;
  localparam logic [7:0] IDX_NUM_ONE    = 8'h27;
  localparam logic [7:0] IDX_DEN_ONE    = 8'h28;
  localparam logic [7:0] IDX_NUM_TWO    = 8'h29;
  localparam logic [7:0] IDX_DEN_TWO    = 8'h2A;
  localparam logic [7:0] IDX_DIVIDER    = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_DIS_ONE     = 1;
  localparam int POS_DIS_TWO     = 2;
  localparam int POS_CUR_SEL     = 3;
  localparam int POS_SEL_ONE     = 4;
  localparam int POS_SEL_TWO     = 6;
  localparam int POS_FLAG_ONE    = 6;
  localparam int POS_FLAG_TWO    = 7;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_RATIO     = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR    = 16'h004B;
  localparam logic [1:0]  SEL_ACTIVE    = 2'h0;
  localparam logic [1:0]  SEL_REACTIVE  = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int LOW_TIME_MS      = 90;
  localparam int LONG_PERIOD_MS   = 180;
  localparam int LOW_TIME_CYC     = (LOW_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int LONG_PERIOD_CYC  = (LONG_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIME_W           = 26;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic active;
    logic reactive;
    logic apparent;
    logic irms;
  } etp_lsb_type;

endpackage : etp_pkg

// [core/etp_top.sv]
// Energy-to-pulse converter: two calibration pulse outputs with APB registers
`timescale 1ns/10ps
`default_nettype none

module etp_top
  import etp_pkg::*;
#(
  parameter int LOW_CYC  = etp_pkg::LOW_TIME_CYC,
  parameter int LONG_CYC = etp_pkg::LONG_PERIOD_CYC
) (
  input  wire logic               REF_CLK,
  input  wire logic               SYS_RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [31:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire etp_pkg::etp_lsb_type ENERGY_LSB,
  output logic                    PULSE_ONE_N,
  output logic                    PULSE_TWO_N,
  output logic                    ENERGY_IRQ,
  output logic      [15:0]        ENERGY_IRQ_VECTOR,
  output logic                    APPARENT_ACC_CURRENT
);
  import etp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nz(input logic [15:0] v);
    nz = (v == 16'h0000) ? 16'h0001 : v;
  endfunction : nz

  function automatic logic pick(input logic [1:0] sel, input logic cur, input etp_lsb_type s);
    if (sel == SEL_ACTIVE) begin
      pick = s.active;
    end else if (sel == SEL_REACTIVE) begin
      pick = s.reactive;
    end else begin
      pick = cur ? s.irms : s.apparent;
    end
  endfunction : pick

  function automatic logic [TIME_W-1:0] low_len(input logic [TIME_W-1:0] per);
    if (per > TIME_W'(LONG_CYC)) begin
      low_len = TIME_W'(LOW_CYC);
    end else if (per > TIME_W'(1)) begin
      low_len = per >> 1;
    end else begin
      low_len = TIME_W'(1);
    end
  endfunction : low_len

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  mode_one_q;
  logic [7:0]  mode_two_q;
  logic [7:0]  en_low_q;
  logic [7:0]  en_mid_q;
  logic [7:0]  en_hi_q;
  logic [1:0]  flag_q;
  logic [15:0] num_q [2];
  logic [15:0] den_q [2];
  logic [7:0]  divider_q;
  logic [1:0]  out_evt;
  logic [1:0]  out_n;

  logic        wr_en;
  logic [7:0]  idx;
  logic        mapped;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  assign idx    = PADDR[9:2];
  assign wr_en  = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;

  function automatic logic wr_hit(input logic [7:0] target);
    wr_hit = wr_en && mapped && (idx == target);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------

  always_comb begin
    mapped = 1'b1;
    PRDATA = 32'h0000_0000;
    unique case (idx)
      IDX_MODE_ONE:   PRDATA[7:0]  = mode_one_q;
      IDX_MODE_TWO:   PRDATA[7:0]  = mode_two_q;
      IDX_IRQ_EN_LOW: PRDATA[7:0]  = en_low_q;
      IDX_IRQ_EN_MID: PRDATA[7:0]  = en_mid_q;
      IDX_IRQ_EN_HI:  PRDATA[7:0]  = en_hi_q;
      IDX_IRQ_ST_MID: PRDATA[7:6]  = flag_q;
      IDX_NUM_ONE:    PRDATA[15:0] = num_q[0];
      IDX_DEN_ONE:    PRDATA[15:0] = den_q[0];
      IDX_NUM_TWO:    PRDATA[15:0] = num_q[1];
      IDX_DEN_TWO:    PRDATA[15:0] = den_q[1];
      IDX_DIVIDER:    PRDATA[7:0]  = divider_q;
      default:        mapped       = 1'b0;
    endcase
    if (PADDR[1:0] != 2'h0 || PADDR[31:10] != 22'h000000) begin
      mapped = 1'b0;
      PRDATA = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Slave error
  // ----------------------------------------------------------------

  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_one_q <= RST_BYTE;
    end else if (wr_hit(IDX_MODE_ONE)) begin
      mode_one_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_two_q <= RST_BYTE;
    end else if (wr_hit(IDX_MODE_TWO)) begin
      mode_two_q <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_low_q <= RST_BYTE;
    end else if (wr_hit(IDX_IRQ_EN_LOW)) begin
      en_low_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_mid_q <= RST_BYTE;
    end else if (wr_hit(IDX_IRQ_EN_MID)) begin
      en_mid_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      en_hi_q <= RST_BYTE;
    end else if (wr_hit(IDX_IRQ_EN_HI)) begin
      en_hi_q <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Ratio and divider
  // ----------------------------------------------------------------

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      divider_q <= RST_BYTE;
    end else if (wr_hit(IDX_DIVIDER)) begin
      divider_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      num_q[0] <= RST_RATIO;
    end else if (wr_hit(IDX_NUM_ONE)) begin
      num_q[0] <= PWDATA[15:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      den_q[0] <= RST_RATIO;
    end else if (wr_hit(IDX_DEN_ONE)) begin
      den_q[0] <= PWDATA[15:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      num_q[1] <= RST_RATIO;
    end else if (wr_hit(IDX_NUM_TWO)) begin
      num_q[1] <= PWDATA[15:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      den_q[1] <= RST_RATIO;
    end else if (wr_hit(IDX_DEN_TWO)) begin
      den_q[1] <= PWDATA[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (out_evt[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_hit(IDX_IRQ_ST_MID) && !PWDATA[POS_FLAG_ONE + i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and current-select outputs
  // ----------------------------------------------------------------

  assign ENERGY_IRQ        = |(flag_q & en_mid_q[POS_FLAG_TWO:POS_FLAG_ONE]);
  assign ENERGY_IRQ_VECTOR = IRQ_VECTOR;
  assign APPARENT_ACC_CURRENT = mode_two_q[POS_CUR_SEL];

  // ----------------------------------------------------------------
  // Converters and pulse shapers
  // ----------------------------------------------------------------
  logic [1:0]        dis;
  logic [1:0]        src;
  logic [7:0]        pre_q    [2];
  logic [16:0]       acc_q    [2];
  logic [TIME_W-1:0] period_q [2];
  logic [TIME_W-1:0] low_q    [2];
  logic [1:0]        dfc;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------

  assign dis[0] = mode_one_q[POS_DIS_ONE];
  assign dis[1] = mode_one_q[POS_DIS_TWO];
  assign src[0] = pick(mode_two_q[POS_SEL_ONE +: 2], mode_two_q[POS_CUR_SEL], ENERGY_LSB);
  assign src[1] = pick(mode_two_q[POS_SEL_TWO +: 2], mode_two_q[POS_CUR_SEL], ENERGY_LSB);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0] den_eff;
    logic [15:0] num_eff;
    logic [16:0] acc_sum;

    // ----------------------------------------------------------------
    // Effective ratio
    // ----------------------------------------------------------------

    assign den_eff = nz(den_q[c]);
    assign num_eff = (nz(num_q[c]) > den_eff) ? den_eff : nz(num_q[c]);
    assign acc_sum = acc_q[c] + {1'b0, num_eff};
    assign dfc[c]  = src[c] && (divider_q <= 8'h01 || pre_q[c] == divider_q - 8'h01);
    assign out_evt[c] = !dis[c] && dfc[c] && acc_sum >= {1'b0, den_eff};

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        pre_q[c] <= 8'h00;
      end else if (src[c]) begin
        pre_q[c] <= dfc[c] ? 8'h00 : pre_q[c] + 8'h01;
      end
    end

    // ----------------------------------------------------------------
    // Ratio accumulator
    // ----------------------------------------------------------------

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        acc_q[c] <= 17'h00000;
      end else if (dis[c]) begin
        acc_q[c] <= 17'h00000;
      end else if (dfc[c]) begin
        acc_q[c] <= out_evt[c] ? acc_sum - {1'b0, den_eff} : acc_sum;
      end
    end

    // ----------------------------------------------------------------
    // Period measurement
    // ----------------------------------------------------------------

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        period_q[c] <= '1;
      end else if (dis[c]) begin
        period_q[c] <= '1;
      end else if (out_evt[c]) begin
        period_q[c] <= TIME_W'(1);
      end else if (period_q[c] != '1) begin
        period_q[c] <= period_q[c] + TIME_W'(1);
      end
    end

    // ----------------------------------------------------------------
    // Low time
    // ----------------------------------------------------------------

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        low_q[c] <= '0;
      end else if (dis[c]) begin
        low_q[c] <= '0;
      end else if (out_evt[c]) begin
        low_q[c] <= low_len(period_q[c]);
      end else if (low_q[c] > TIME_W'(1)) begin
        low_q[c] <= low_q[c] - TIME_W'(1);
      end else begin
        low_q[c] <= '0;
      end
    end

    // ----------------------------------------------------------------
    // Output level
    // ----------------------------------------------------------------

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        out_n[c] <= 1'b1;
      end else if (dis[c]) begin
        out_n[c] <= 1'b1;
      end else if (out_evt[c]) begin
        out_n[c] <= 1'b0;
      end else if (low_q[c] <= TIME_W'(1)) begin
        out_n[c] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------

  assign PULSE_ONE_N = out_n[0];
  assign PULSE_TWO_N = out_n[1];

endmodule : etp_top

`default_nettype wire

// [verif/etp_monitor.sv]
// Checker for the energy-to-pulse converter ports
`timescale 1ns/10ps
`default_nettype none
module etp_monitor
  import etp_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire etp_lsb_type ENERGY_LSB,
  input wire logic        PULSE_ONE_N,
  input wire logic        ENERGY_IRQ,
  input wire logic [15:0] ENERGY_IRQ_VECTOR,
  input wire logic        APPARENT_ACC_CURRENT
);
  // ----------------------------------------------------------------
  // Register shadows
  // ----------------------------------------------------------------
  logic [7:0] m1_q;
  logic [7:0] m2_q;
  logic [7:0] en_q;
  wire logic  wr = PSEL & PENABLE & PWRITE;
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction : ad
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      m1_q <= 8'h00;
      m2_q <= 8'h00;
      en_q <= 8'h00;
    end else if (wr) begin
      if (PADDR == ad(IDX_MODE_ONE)) m1_q <= PWDATA[7:0];
      if (PADDR == ad(IDX_MODE_TWO)) m2_q <= PWDATA[7:0];
      if (PADDR == ad(IDX_IRQ_EN_MID)) en_q <= PWDATA[7:0];
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_vec; ENERGY_IRQ_VECTOR == IRQ_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_src; $fell(PULSE_ONE_N) |-> $past(ENERGY_LSB) != 4'h0; endproperty
  a_src: assert property (p_src) else $error("pulse without event");
  property p_dis; m1_q[1] && $past(m1_q[1]) |-> PULSE_ONE_N; endproperty
  a_dis: assert property (p_dis) else $error("disabled output low");
  property p_flag; $fell(PULSE_ONE_N) && en_q[6] |-> ENERGY_IRQ; endproperty
  a_flag: assert property (p_flag) else $error("no irq on pulse");
  property p_mask; en_q[7:6] == 2'h0 |-> !ENERGY_IRQ; endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");
  property p_hold;
    ENERGY_IRQ && !(wr && (PADDR == ad(IDX_IRQ_ST_MID) || PADDR == ad(IDX_IRQ_EN_MID))) |=> ENERGY_IRQ;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_cur; APPARENT_ACC_CURRENT == m2_q[3]; endproperty
  a_cur: assert property (p_cur) else $error("current select wrong");
  property p_low; $fell(PULSE_ONE_N) && !wr |=> !PULSE_ONE_N; endproperty
  a_low: assert property (p_low) else $error("low too short");
endmodule : etp_monitor
bind etp_top etp_monitor u_mon (.*);
`default_nettype wire

// [verif/etp_cal_meter.sv]
// Calibration meter model counting pulses
`timescale 1ns/10ps
`default_nettype none
module etp_cal_meter (
  input wire logic clk,
  input wire logic pulse_n,
  output var int   falls,
  output var int   width
);
  int run = 0;
  initial falls = 0;
  initial width = 0;
  always @(negedge pulse_n) falls++;
  always @(posedge clk) begin
    if (!pulse_n) run++;
    else if (run != 0) begin
      width = run;
      run = 0;
    end
  end
endmodule : etp_cal_meter
`default_nettype wire

// [verif/tb_energy_to_pulse_converter.sv]
// Testbench for the energy-to-pulse converter
`timescale 1ns/10ps
`default_nettype none
module tb_energy_to_pulse_converter;
  import etp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic prdy, perr, er, p1_n, p2_n, irq, cur;
  logic [15:0] vec;
  etp_lsb_type lsb = 4'h0;
  etp_lsb_type m;
  logic [1:0] s;
  logic [7:0] idx[8] = '{IDX_MODE_ONE, IDX_MODE_TWO, IDX_IRQ_EN_LOW, IDX_IRQ_EN_MID,
                         IDX_IRQ_EN_HI, IDX_IRQ_ST_MID, IDX_NUM_ONE, IDX_DEN_ONE};
  int err_total = 0, samples_checked = 0, cyc = 0, seed = 32'h2A1F;
  int f1, f2, w1, w2, f, g, n, d, en, ed;
  always #2.5 clk = ~clk;
  etp_top #(.LOW_CYC(20), .LONG_CYC(40)) u_dut (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy),
    .PSLVERR(perr), .ENERGY_LSB(lsb), .PULSE_ONE_N(p1_n), .PULSE_TWO_N(p2_n), .ENERGY_IRQ(irq),
    .ENERGY_IRQ_VECTOR(vec), .APPARENT_ACC_CURRENT(cur));
  etp_cal_meter u_m1 (.clk(clk), .pulse_n(p1_n), .falls(f1), .width(w1));
  etp_cal_meter u_m2 (.clk(clk), .pulse_n(p2_n), .falls(f2), .width(w2));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] v);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= v;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic fire(input etp_lsb_type v, input int gap);
    lsb <= v;
    @(posedge clk);
    lsb <= 4'h0;
    repeat (gap - 1) @(posedge clk);
  endtask : fire
  function automatic etp_lsb_type want(input int k, input int c);
    return (k == 0) ? 4'h8 : (k == 1) ? 4'h4 : (c != 0) ? 4'h1 : 4'h2;
  endfunction : want
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(vec, IRQ_VECTOR);
    foreach (idx[k]) begin
      apb(1'b0, idx[k], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h31, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      s = 2'(i / 2);
      m = want(i / 2, i % 2);
      apb(1'b1, IDX_MODE_TWO, {24'h0, s, s, 1'(i % 2), 3'h0});
      chk(cur, 32'(i % 2));
      f = f1;
      g = f2;
      fire(~m, 60);
      chk(f1 + f2, f + g);
      fire(m, 60);
      chk(f1 + f2, f + g + 2);
    end
    apb(1'b1, IDX_MODE_TWO, 32'h0);
    fire(4'h8, 60);
    chk(w1, 20);
    repeat (4) fire(4'h8, 10);
    repeat (30) @(posedge clk);
    chk(w1, 5);
    apb(1'b1, IDX_IRQ_EN_MID, 32'hC0);
    apb(1'b1, IDX_IRQ_ST_MID, 32'h0);
    chk(irq, 0);
    fire(4'h8, 60);
    chk(irq, 1);
    apb(1'b0, IDX_IRQ_ST_MID, 32'h0);
    chk(rd, 32'hC0);
    apb(1'b1, IDX_IRQ_ST_MID, 32'h80);
    chk(irq, 1);
    apb(1'b1, IDX_IRQ_ST_MID, 32'h0);
    apb(1'b1, IDX_IRQ_EN_MID, 32'h0);
    fire(4'h8, 60);
    chk(irq, 0);
    apb(1'b1, IDX_DIVIDER, 32'h3);
    f = f1;
    repeat (6) fire(4'h8, 60);
    chk(f1 - f, 2);
    apb(1'b1, IDX_DIVIDER, 32'h0);
    for (int k = 0; k < 5; k++) begin
      n = $unsigned($random(seed)) % 6;
      d = (k == 0) ? 0 : $unsigned($random(seed)) % 4 + 1;
      ed = (d == 0) ? 1 : d;
      en = (n == 0) ? 1 : (n > ed) ? ed : n;
      apb(1'b1, IDX_NUM_ONE, {$random(seed)} & 32'hFFFF0000 | n);
      apb(1'b0, IDX_NUM_ONE, 32'h0);
      chk(rd, 32'(n));
      apb(1'b1, IDX_DEN_ONE, 32'(d));
      apb(1'b1, IDX_MODE_ONE, 32'h2);
      f = f1;
      fire(4'h8, 60);
      chk(f1, f);
      apb(1'b1, IDX_MODE_ONE, 32'h0);
      repeat (8) fire(4'h8, 60);
      chk(f1 - f, (8 * en) / ed);
    end
    wrap_up();
  end
endmodule : tb_energy_to_pulse_converter
`default_nettype wire
